//--- bench/rail_host_model.sv
// rail_host_model: host processor and front panel around the sequencer pins.
// assumes the bench sets press, request and fault wishes on rising edges.
`timescale 1ns/10ps
`default_nettype none
module rail_host_model
    import rail_seq_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_press,
    input  wire logic       i_host_want,
    input  wire logic       i_slow,
    input  wire logic [2:0] i_fault,
    output wire pins_t      o_pins
);
    int   wait_q = 0;
    logic host_q = 1'b0;

    // the host raises its request a while after it wants power and drops it at once;
    // the slow setting keeps the device waiting in the await state for a while
    always @(posedge i_clk)
    begin
        wait_q <= i_host_want ? wait_q + 1 : 0;
        host_q <= i_host_want && (wait_q >= (i_slow ? 30 : 1));
    end

    // line detect stays released, so no boot wake and no line wake
    assign o_pins = '{~i_press, 1'b1, host_q, i_fault[2], i_fault[1], i_fault[0]};
endmodule
`default_nettype wire

//--- bench/rail_power_sequencer_bench.sv
// rail_power_sequencer_bench: self-checking bench of the rail sequencer.
// assumes the host model drives the pins; the bench is the apb master.
`timescale 1ns/10ps
`default_nettype none
module rail_power_sequencer_bench
    import rail_seq_pkg::*;
;
    // ----------------------------------------------------------------
    // clock, reset, design and partner
    // ----------------------------------------------------------------
    localparam int TK = 10; // clocks per ms, keeps the 500 ms walk short
    logic       i_clk  = 1'b0;
    logic       i_rstn = 1'b0;
    apb_req_t   req    = '0;
    apb_rsp_t   rsp;
    pins_t      pins;
    logic [4:0] en;
    logic [4:0] dis;
    logic       ls;
    logic       good;
    logic       press  = 1'b0;
    logic       want   = 1'b0;
    logic [2:0] fault  = 3'h0;
    int         n_errors = 0;
    int         checked  = 0;
    int         cyc      = 0;
    int         t0;
    int         t1;
    always #5 i_clk = ~i_clk;
    rail_power_sequencer #(.TICK_CYCLES_P(TK)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_apb(req), .i_pins(pins), .o_apb(rsp), .o_rail_en(en),
        .o_rail_discharge(dis), .o_load_switch(ls), .o_rails_good_out(good));
    rail_host_model i_host (.i_clk(i_clk), .i_press(press), .i_host_want(want),
        .i_slow(1'b1), .i_fault(fault), .o_pins(pins));

    // cycle count, also the hang guard
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic near(input string nm, input int got, input int exp);
        chk(nm, 32'h0000_0001, 32'((got >= exp - 3) && (got <= exp + 3)));
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        r = rsp.prdata;
        e = rsp.pslverr;
        chk("pready", 32'h0000_0001, 32'(rsp.pready));
        req <= '0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                      input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk("prdata", x, r & m);
        chk("pslverr", 32'(err), 32'(e));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic wait_en(input logic [4:0] v);
        int n;
        n = 0;
        while (en !== v && n < 6000)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("rail_en", 32'h0000_0000, 32'(en));
        chk("discharge", 32'h0000_001f, 32'(dis));
        rd(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0001, 1'b0);
        rd(ADDR_SEQ, 32'hffff_ffff, 32'h0007_6543, 1'b0);
        rd(ADDR_GAP, 32'hffff_ffff, 32'h0000_0000, 1'b0);
        rd(12'h014, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    endtask

    // rail0 unsequenced and switched by software; gap three set to 5 ms
    task automatic t_power_up();
        wr(ADDR_SEQ, 32'h000a_7330);
        wr(ADDR_GAP, 32'h0000_0030);
        wr(ADDR_ENA, 32'h0000_0021);
        chk("rail_en", 32'h0000_0001, 32'(en));
        chk("load", 32'h0000_0001, 32'(ls));
        t0 = cyc;
        press <= 1'b1;
        want  <= 1'b1;
        wait_en(5'h07);
        near("wake to strobe3", cyc - t0, 44);
        t0 = cyc;
        rd(ADDR_ENA, 32'h0000_0000, 32'h0000_0000, 1'b1);
        wait_en(5'h0f);
        near("strobe3 to 7", cyc - t0, 110);
        t0 = cyc;
        wait_en(5'h1f);
        near("strobe7 to 10", cyc - t0, 60);
        chk("discharge", 32'h0000_0000, 32'(dis));
        press <= 1'b0;
        repeat (10) @(posedge i_clk);
        rd(ADDR_STAT, 32'h0000_0007, 32'h0000_0002, 1'b0);
        rd(ADDR_ENA, 32'h0000_003f, 32'h0000_003f, 1'b0);
        chk("good", 32'h0000_0001, 32'(good));
    endtask

    // host drops: reverse walk with tenfold gaps, off after 500 ms
    task automatic t_power_down();
        t0 = cyc;
        want <= 1'b0;
        wait_en(5'h0e);
        chk("pd start", 32'h0000_0001, 32'(cyc - t0 < 8));
        chk("good", 32'h0000_0000, 32'(good));
        chk("discharge", 32'h0000_0011, 32'(dis));
        t1 = cyc;
        wait_en(5'h06);
        near("strobe10 to 7", cyc - t1, 600);
        t1 = cyc;
        wait_en(5'h00);
        near("strobe7 to 3", cyc - t1, 1100);
        while (cyc - t0 < 4985) @(posedge i_clk);
        chk("load", 32'h0000_0001, 32'(ls));
        rd(ADDR_STAT, 32'h0000_0007, 32'h0000_0005, 1'b0);
        while (cyc - t0 < 5025) @(posedge i_clk);
        chk("load", 32'h0000_0000, 32'(ls));
        rd(ADDR_STAT, 32'h0000_0007, 32'h0000_0000, 1'b0);
    endtask

    // thermal fault from await goes to recovery and blocks wake until cleared
    task automatic t_fault();
        press <= 1'b1;
        wait_en(5'h1e);
        press <= 1'b0;
        fault <= 3'h2;
        wait_en(5'h0e);
        chk("good", 32'h0000_0000, 32'(good));
        repeat (5100) @(posedge i_clk);
        rd(ADDR_STAT, 32'h0000_0007, 32'h0000_0004, 1'b0);
        chk("rail_en", 32'h0000_0000, 32'(en));
        fault <= 3'h0;
        wait_en(5'h1e);
        chk("rail_en", 32'h0000_001e, 32'(en));
    endtask

    // host drop with suspend chosen: free rail0 stays on, host level wakes again
    task automatic t_suspend();
        wr(ADDR_ENA, 32'h0000_001f);
        wr(ADDR_CTRL, 32'h0000_0004);
        want <= 1'b1;
        repeat (40) @(posedge i_clk);
        t0 = cyc;
        want <= 1'b0;
        while (cyc - t0 < 5025) @(posedge i_clk);
        rd(ADDR_STAT, 32'h0000_0007, 32'h0000_0003, 1'b0);
        chk("rail_en", 32'h0000_0001, 32'(en));
        chk("good", 32'h0000_0000, 32'(good));
        want <= 1'b1;
        wait_en(5'h1f);
        chk("rail_en", 32'h0000_001f, 32'(en));
    endtask

    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_power_up();
        t_power_down();
        t_fault();
        t_suspend();
        stop_test();
    end
endmodule
`default_nettype wire

//--- src/rail_ms_tick.sv
// rail_ms_tick: one-cycle pulse every CYCLES clocks, restartable.
// assumes i_restart comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rail_ms_tick #(
    parameter int CYCLES = 100000
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_restart,
    output logic      o_tick
);
    localparam int W = $clog2(CYCLES);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } tick_state_t;

    tick_state_t q;
    tick_state_t n;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    // restart realigns the phase so timed intervals are whole periods
    always_comb
    begin
        n = q;
        n.tick = 1'b0;
        if (i_restart)
        begin
            n.cnt = '0;
        end
        else if (q.cnt == W'(CYCLES - 1))
        begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.cnt = q.cnt + W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            q <= '0;
        else
            q <= n;
    end

    assign o_tick = q.tick;

endmodule
`default_nettype wire

//--- src/rail_power_sequencer.sv
// rail_power_sequencer: power-state machine and ten-strobe rail sequencer
// with an APB register slave.
// assumes pins are asynchronous and i_rstn is held low while bias is lost.
//
// Summary of operation
// (RL1) power-up walks ten strobes with nine gaps; strobes enable their rails
// (RL2) each rail holds one strobe number; several rails may share a strobe
// (RL3) each gap is selectable from 2 ms to 5 ms
// (RL4) strobe one fires at once, then each gap precedes the next strobe
// (RL5) off wakes on button/line fall, host high, or boot with line low
// (RL6) suspend wakes on button/line fall or host high, unless blocked
// (RL7) wake enters await state; released inputs and no host for 20 s -> off
// (RL8) host request moves to active; there host request low, a fault or a long press ends it
// (RL9) rails with strobe zero are never touched by sequencing; the code drops them at power-down start when going to off or recovery
// (RL10) rail enable register refuses access while sequencing runs
// (RL11) rail enable bits always show actual rail state
// (RL12) power-down walks strobes ten downward, disabling and discharging rails
// (RL13) power-down gaps stretch tenfold under one global stretch bit
// (RL14) power-down always ends exactly 500 ms after it starts
// (RL15) in active, host request low starts power-down
// (RL16) button held over 8 s, or 15 s if selected, starts power-down
// (RL17) thermal, lockout or rail fault starts power-down
// (RL18) going to suspend leaves unsequenced rails as they were
// (RL19) going to off or recovery drops unsequenced rails at start
// (RL20) load switch turns off on entering off or recovery
// (RL21) on bias loss core resets, rails off with discharge on
// (RL22) strobes one and two carry no rails, yet their gaps elapse
// (RL23) rails-good is low during power-down and suspend
// (RL24) all times count the ms time base, restarted on timed entries
`timescale 1ns/10ps
`default_nettype none
module rail_power_sequencer
    import rail_seq_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire apb_req_t         i_apb,
    input  wire pins_t            i_pins,
    output apb_rsp_t              o_apb,
    output logic [NRAIL-1:0]      o_rail_en,
    output logic [NRAIL-1:0]      o_rail_discharge,
    output logic                  o_load_switch,
    output logic                  o_rails_good_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pins_t      s1;
        pins_t      s2;
        pins_t      prev;
        logic [1:0] boot;
        pstate_t    st;
        pstate_t    tgt;
        logic       pu_busy;
        logic       pdone;
        logic [3:0] step;
        logic [5:0] gap;
        logic [14:0] tmr;
        logic [13:0] press;
        logic [2:0] ctrl;
        logic [NRAIL*SEQ_W-1:0] seq;
        logic [NGAP*GAP_W-1:0]  gaps;
        logic [NRAIL-1:0] rail_en;
        logic [NRAIL-1:0] dis;
        logic       ls;
        logic       good;
        logic       restart;
        apb_rsp_t   rsp;
    } sq_t;

    // bias loss holds reset: every rail off with its discharge path on
    localparam sq_t SQ_RST = '{s1: PINS_IDLE, s2: PINS_IDLE, prev: PINS_IDLE,
                               boot: 2'h3, st: ST_OFF, tgt: ST_OFF,
                               ctrl: CTRL_RST, seq: SEQ_RST, gaps: GAP_RST,
                               dis: '1, default: '0}; // [RL21]

    sq_t  q;
    sq_t  n;
    logic tick;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // one 4-bit field per rail, so a rail can only match one strobe
    function automatic logic [NRAIL-1:0] strobe_mask(
        input logic [NRAIL*SEQ_W-1:0] seq,
        input logic [3:0]             k
    );
        logic [NRAIL-1:0] m;
        m = '0;
        for (int i = 0; i < NRAIL; i++)
            m[i] = (seq[i*SEQ_W +: SEQ_W] == k); // [RL2]
        return m;
    endfunction

    // gap number g (1..9) in ms; code 0..3 selects 2..5 ms
    function automatic logic [5:0] gap_ms(
        input logic [NGAP*GAP_W-1:0] gaps,
        input logic [3:0]            g,
        input logic                  stretch
    );
        logic [5:0] base;
        base = {4'h0, gaps[(int'(g) - 1)*GAP_W +: GAP_W]} + GAP_BASE; // [RL3]
        return stretch ? 6'(base * GAP_MULT) : base; // [RL13]
    endfunction

    // power-down entry; suspend keeps unsequenced rails as they are
    function automatic sq_t go_down(input sq_t s, input pstate_t t);
        logic [NRAIL-1:0] m0;
        m0 = strobe_mask(s.seq, SEQ_NONE);
        s.st      = ST_PDOWN;
        s.tgt     = t;
        s.pu_busy = 1'b0;
        s.pdone   = 1'b0;
        s.step    = STROBE_LAST; // [RL12]
        s.gap     = '0;
        s.tmr     = '0;
        s.restart = 1'b1;
        if (t != ST_SUSPEND) // [RL18]
        begin
            s.rail_en = s.rail_en & ~m0; // [RL19]
            s.dis     = s.dis | m0;
        end
        return s;
    endfunction

    function automatic sq_t go_wake(input sq_t s);
        s.st      = ST_WAIT; // [RL7]
        s.pu_busy = 1'b1;
        s.step    = STROBE_FIRST;
        s.gap     = '0;
        s.tmr     = '0;
        s.restart = 1'b1;
        return s;
    endfunction

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    rail_ms_tick #(
        .CYCLES (TICK_CYCLES_P)
    ) u_tick (
        .i_clk     (i_clk),
        .i_rstn    (i_rstn),
        .i_restart (q.restart),
        .o_tick    (tick)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic       btn_fall;
    logic       line_fall;
    logic       blocked;
    logic       fault;
    logic       long_press;
    logic       busy;
    logic       acc;
    logic [13:0] held;

    always_comb
    begin
        n         = q;
        n.restart = 1'b0;
        // two-flop synchronisers; edges are taken past the second flop
        n.s1      = i_pins;
        n.s2      = q.s1;
        n.prev    = q.s2;
        if (q.boot != 2'h0)
            n.boot = q.boot - 2'h1;

        btn_fall   = q.prev.button & ~q.s2.button;
        line_fall  = q.prev.line & ~q.s2.line;
        blocked    = q.s2.lockout | q.s2.thermal;
        fault      = blocked | q.s2.rail_fault;
        held       = q.ctrl[CTRL_LONGSEL] ? PRESS_LONG : PRESS_SHORT;
        long_press = (q.press >= held);
        busy       = q.pu_busy | (q.st == ST_PDOWN);
        acc        = i_apb.psel & i_apb.penable;

        // ms counters; saturate so a long stay never wraps
        if (tick && q.tmr != '1)
            n.tmr = q.tmr + 15'h1; // [RL24]
        if (q.s2.button)
            n.press = '0;
        else if (tick && q.press != '1)
            n.press = q.press + 14'h1;

        // apb: one wait state, answer and error decided before pready
        n.rsp.pready  = acc & ~q.rsp.pready;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata  = '0;
        if (acc && !q.rsp.pready)
        begin
            case (i_apb.paddr)
                ADDR_CTRL: n.rsp.prdata = {29'h0, q.ctrl};
                ADDR_SEQ:  n.rsp.prdata = {12'h0, q.seq};
                ADDR_GAP:  n.rsp.prdata = {14'h0, q.gaps};
                ADDR_ENA:
                begin
                    n.rsp.prdata  = {26'h0, q.ls, q.rail_en}; // [RL11]
                    n.rsp.pslverr = busy; // [RL10]
                end
                ADDR_STAT: n.rsp.prdata = {24'h0, q.step, busy, q.st};
                default:   n.rsp.pslverr = 1'b1;
            endcase
        end
        // write lands on the completing edge unless refused
        if (acc && q.rsp.pready && i_apb.pwrite && !q.rsp.pslverr)
        begin
            case (i_apb.paddr)
                ADDR_CTRL: n.ctrl = i_apb.pwdata[2:0];
                ADDR_SEQ:  n.seq  = i_apb.pwdata[NRAIL*SEQ_W-1:0];
                ADDR_GAP:  n.gaps = i_apb.pwdata[NGAP*GAP_W-1:0];
                ADDR_ENA:
                begin
                    n.rail_en = i_apb.pwdata[NRAIL-1:0];
                    n.ls      = i_apb.pwdata[ENA_LS];
                    n.dis     = ~i_apb.pwdata[NRAIL-1:0];
                end
                default: n.ctrl = q.ctrl;
            endcase
        end

        // power states
        case (q.st)
            ST_OFF:
            begin
                if (!blocked && (btn_fall || line_fall || q.s2.host
                    || (q.boot == 2'h1 && !q.s2.line)))
                    n = go_wake(n); // [RL5]
            end
            ST_SUSPEND:
            begin
                if (fault)
                    n = go_down(n, ST_RECOVER); // [RL17]
                else if (long_press)
                    n = go_down(n, ST_OFF); // [RL16]
                else if (btn_fall || line_fall || q.s2.host)
                    n = go_wake(n); // [RL6]
            end
            ST_WAIT:
            begin
                if (fault)
                    n = go_down(n, ST_RECOVER); // [RL17]
                else if (long_press)
                    n = go_down(n, ST_OFF); // [RL16]
                else if (q.s2.host)
                    n.st = ST_ACTIVE; // [RL8]
                else if (q.s2.button && q.s2.line && q.tmr >= WAIT_REQ_TMR)
                    n = go_down(n, ST_OFF); // [RL7]
            end
            ST_ACTIVE:
            begin
                // line detect is not looked at here
                if (fault)
                    n = go_down(n, ST_RECOVER); // [RL17]
                else if (long_press)
                    n = go_down(n, ST_OFF); // [RL16]
                else if (!q.s2.host) // [RL8]
                    n = go_down(n, q.ctrl[CTRL_SUSPEND] ? ST_SUSPEND : ST_OFF); // [RL15]
            end
            ST_RECOVER:
            begin
                if (!fault)
                    n = go_wake(n);
            end
            ST_PDOWN:
            begin
                if (tick && q.tmr == PD_TOTAL_TMR - 15'h1)
                begin
                    n.st  = q.tgt; // [RL14]
                    n.tmr = '0;
                    if (q.tgt != ST_SUSPEND)
                        n.ls = 1'b0; // [RL20]
                end
            end
            default: n.st = ST_OFF;
        endcase

        // power-up strobes; a power-down taking over cancels the walk
        if (q.pu_busy && n.st != ST_PDOWN)
        begin
            if (q.gap == '0)
            begin
                if (q.step >= STROBE_LIVE) // [RL22]
                begin
                    n.rail_en = n.rail_en | strobe_mask(q.seq, q.step); // [RL1]
                    n.dis     = n.dis & ~strobe_mask(q.seq, q.step);
                end
                if (q.step == STROBE_LAST)
                    n.pu_busy = 1'b0;
                else
                begin
                    n.step = q.step + 4'h1; // [RL4]
                    n.gap  = gap_ms(q.gaps, q.step, 1'b0);
                end
            end
            else if (tick)
                n.gap = q.gap - 6'h1;
        end

        // power-down strobes; the walk stops after strobe three
        if (q.st == ST_PDOWN && n.st == ST_PDOWN && !q.pdone)
        begin
            if (q.gap == '0)
            begin
                n.rail_en = n.rail_en & ~strobe_mask(q.seq, q.step); // [RL12]
                n.dis     = n.dis | strobe_mask(q.seq, q.step);
                if (q.step == STROBE_LIVE) // [RL22]
                    n.pdone = 1'b1;
                else
                begin
                    n.step = q.step - 4'h1;
                    n.gap  = gap_ms(q.gaps, q.step - 4'h1, q.ctrl[CTRL_STRETCH]);
                end
            end
            else if (tick)
                n.gap = q.gap - 6'h1;
        end

        // rails-good only when awake, walk finished and rails healthy
        n.good = (n.st == ST_WAIT || n.st == ST_ACTIVE) && !n.pu_busy
                 && !q.s2.rail_fault && (n.rail_en != '0); // [RL23]
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            q <= SQ_RST;
        else
            q <= n;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_apb            = q.rsp;
    assign o_rail_en        = q.rail_en;
    assign o_rail_discharge = q.dis;
    assign o_load_switch    = q.ls;
    assign o_rails_good_out = q.good;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    property p_refuse;
        acc && !o_apb.pready && i_apb.paddr == ADDR_ENA && busy
            |=> o_apb.pready && o_apb.pslverr;
    endproperty
    a_refuse: assert property (p_refuse) else $error("enable access not refused"); // [RL10]

    property p_good_low;
        (q.st == ST_PDOWN || q.st == ST_SUSPEND) |-> !o_rails_good_out;
    endproperty
    a_good_low: assert property (p_good_low) else $error("rails-good high"); // [RL23]

    property p_ls_off;
        q.st == ST_OFF && $past(q.st) == ST_PDOWN |-> !o_load_switch;
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("load switch left on"); // [RL20]

    property p_host_drop;
        q.st == ST_ACTIVE && !q.s2.host |=> q.st == ST_PDOWN;
    endproperty
    a_host_drop: assert property (p_host_drop) else $error("no power-down"); // [RL15]

    property p_pd_total;
        $fell(q.st == ST_PDOWN) |-> $past(q.tmr) == PD_TOTAL_TMR - 15'h1;
    endproperty
    a_pd_total: assert property (p_pd_total) else $error("bad power-down length"); // [RL14]

    property p_unassigned;
        q.pu_busy && n.st != ST_PDOWN |=>
            ((o_rail_en ^ $past(o_rail_en)) & $past(strobe_mask(q.seq, SEQ_NONE))) == '0;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("free rail moved"); // [RL9]

    property p_dead_strobes;
        q.pu_busy && q.step < STROBE_LIVE && n.st != ST_PDOWN
            |=> o_rail_en == $past(o_rail_en);
    endproperty
    a_dead_strobes: assert property (p_dead_strobes) else $error("early rail"); // [RL22]

    property p_long_press;
        (q.st == ST_WAIT || q.st == ST_ACTIVE || q.st == ST_SUSPEND)
            && long_press |=> q.st == ST_PDOWN;
    endproperty
    a_long_press: assert property (p_long_press) else $error("long press ignored"); // [RL16]

    property p_wake;
        q.st == ST_OFF && btn_fall && !blocked |=> q.st == ST_WAIT ##1 q.step == 4'h2;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not taken"); // [RL5]

    c_active:  cover property (q.st == ST_WAIT ##1 q.st == ST_ACTIVE);
    c_suspend: cover property (q.st == ST_PDOWN ##1 q.st == ST_SUSPEND);
    c_recover: cover property (q.st == ST_PDOWN ##1 q.st == ST_RECOVER);

endmodule
`default_nettype wire

//--- src/rail_seq_pkg.sv
// rail_seq_pkg: register map, field layout, reset values, timing and
// carrier types for the rail power sequencer.
// assumes a 100 MHz core clock and a one-millisecond sequencing time base.
package rail_seq_pkg;

    // ----------------------------------------------------------------
    // clock and time base
    // ----------------------------------------------------------------
    localparam int CLK_NS      = 10;
    localparam int MS_NS       = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_NS;
    localparam int MS_PER_S    = 1000;

    // ----------------------------------------------------------------
    // sequencing times, in their own units, then in ms ticks
    // ----------------------------------------------------------------
    localparam int WAIT_REQ_S    = 20;
    localparam int PRESS_SHORT_S = 8;
    localparam int PRESS_LONG_S  = 15;
    localparam int PD_TOTAL_MS   = 500;
    localparam int GAP_MIN_MS    = 2;
    localparam int GAP_STRETCH   = 10;
    localparam logic [14:0] WAIT_REQ_TMR = 15'(WAIT_REQ_S * MS_PER_S);
    localparam logic [13:0] PRESS_SHORT  = 14'(PRESS_SHORT_S * MS_PER_S);
    localparam logic [13:0] PRESS_LONG   = 14'(PRESS_LONG_S * MS_PER_S);
    localparam logic [14:0] PD_TOTAL_TMR = 15'(PD_TOTAL_MS);
    localparam logic [5:0]  GAP_BASE     = 6'(GAP_MIN_MS);
    localparam logic [5:0]  GAP_MULT     = 6'(GAP_STRETCH);

    // ----------------------------------------------------------------
    // strobes and rails
    // ----------------------------------------------------------------
    localparam int NRAIL = 5;
    localparam int SEQ_W = 4;
    localparam int GAP_W = 2;
    localparam int NGAP  = 9;
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_LIVE  = 4'h3;
    localparam logic [3:0] STROBE_LAST  = 4'ha;
    localparam logic [3:0] SEQ_NONE     = 4'h0;

    // ----------------------------------------------------------------
    // register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SEQ  = 12'h004;
    localparam logic [11:0] ADDR_GAP  = 12'h008;
    localparam logic [11:0] ADDR_ENA  = 12'h00c;
    localparam logic [11:0] ADDR_STAT = 12'h010;
    localparam int CTRL_STRETCH = 0;
    localparam int CTRL_LONGSEL = 1;
    localparam int CTRL_SUSPEND = 2;
    localparam int ENA_LS       = 5;
    localparam logic [2:0]  CTRL_RST = 3'h1;
    localparam logic [19:0] SEQ_RST  = 20'h7_6543;
    localparam logic [17:0] GAP_RST  = 18'h0_0000;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_WAIT    = 3'b001,
        ST_ACTIVE  = 3'b010,
        ST_SUSPEND = 3'b011,
        ST_RECOVER = 3'b100,
        ST_PDOWN   = 3'b101
    } pstate_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic button;
        logic line;
        logic host;
        logic lockout;
        logic thermal;
        logic rail_fault;
    } pins_t;

    // released button and line sit high, host request low
    localparam pins_t PINS_IDLE = 6'b11_0000;

endpackage
